// [design/wstu_top.sv]
`default_nettype none
module wstu_top (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [31:0] wb_adr_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic wb_we_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic signed [wstu_pkg::SAMPLE_W-1:0] sample_a_in,
    input wire logic signed [wstu_pkg::SAMPLE_W-1:0] sample_b_in,
    input wire logic [3:0] trig_in,
    output logic [3:0] trig_out,
    output logic trig_pulse_out,
    output logic [wstu_pkg::PC_W-1:0] pc_out,
    output logic [3:0] seq_state_out
);
    wstu_pkg::wstu_wb_req_s req;
    wstu_pkg::wstu_trig_cfg_s cfg;
    logic [10:0] ctrl_reg;
    logic signed [wstu_pkg::SAMPLE_W-1:0] level_reg;
    logic [15:0] hyst_reg;
    logic [15:0] fsr_reg;
    logic [5:0] seq_ctrl_reg;
    logic [10:0] prog_len_reg;
    logic [wstu_pkg::INSTR_W-1:0] cache_reg [wstu_pkg::CACHE_DEPTH];
    logic [wstu_pkg::PC_W-1:0] wr_idx_reg;
    logic [3:0] trig_meta_reg;
    logic [3:0] trig_sync_reg;
    logic [3:0] trig_out_reg;
    logic [wstu_pkg::SAMPLE_W-1:0] samp_reg;
    logic trig_flag_reg;
    logic aux_flag_reg;
    logic aux_prev_reg;
    logic trig_pulse_reg;
    logic [wstu_pkg::PC_W-1:0] pc_reg;
    wstu_pkg::wstu_seq_e state_reg;
    logic [31:0] dat_reg;
    logic ack_reg;
    logic analog_hit;
    logic gate_ok;
    logic trig_evt;
    logic aux_src;
    logic aux_rise;
    logic wr_acc;
    logic rd_acc;
    logic force_wr;
    logic clr_wr;
    logic [wstu_pkg::INSTR_W-1:0] instr;
    logic [6:0] mem_pct;
    logic [31:0] rd_data;
    logic ready;

    assign req = '{adr: wb_adr_in, dat: wb_dat_in, sel: wb_sel_in, we: wb_we_in,
                   cyc: wb_cyc_in, stb: wb_stb_in};
    assign wr_acc = req.cyc && req.stb && req.we && !ack_reg;
    assign rd_acc = req.cyc && req.stb && !req.we && !ack_reg;
    assign force_wr = wr_acc && req.adr[7:0] == wstu_pkg::REG_CTRL
                      && req.dat[wstu_pkg::CTRL_FORCE_BIT];
    assign clr_wr = wr_acc && req.adr[7:0] == wstu_pkg::REG_CTRL
                    && req.dat[wstu_pkg::CTRL_CLR_BIT];

    assign cfg = '{slope: ctrl_reg[wstu_pkg::CTRL_SLOPE_LSB +: 2],
                   hyst_rel: ctrl_reg[wstu_pkg::CTRL_HYST_REL_BIT],
                   level: level_reg, hyst: hyst_reg, fsr: fsr_reg};

    // Sample source held in a register so the comparator sees a stable value
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            // Most negative code, so a reset level of zero never reads as crossed
            samp_reg <= {1'b1, {(wstu_pkg::SAMPLE_W-1){1'b0}}};
        end else begin
            samp_reg <= ctrl_reg[wstu_pkg::CTRL_SRC_BIT] ? sample_b_in : sample_a_in;
        end
    end

    wstu_analog_trig u_analog (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .sample_in(samp_reg),
        .cfg_in(cfg),
        .hit_out(analog_hit)
    );

    // Trigger pins are asynchronous to our clock
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            trig_meta_reg <= 4'h0;
            trig_sync_reg <= 4'h0;
        end else begin
            trig_meta_reg <= trig_in;
            trig_sync_reg <= trig_meta_reg;
        end
    end

    assign gate_ok = !ctrl_reg[wstu_pkg::CTRL_GATE_EN_BIT]
                     || (ctrl_reg[wstu_pkg::CTRL_GATE_SEL_BIT] ? trig_sync_reg[3]
                                                               : trig_sync_reg[2]);
    // Force bypasses source and gate alike
    assign trig_evt = force_wr || (analog_hit && gate_ok);

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            trig_pulse_reg <= 1'b0;
        end else begin
            trig_pulse_reg <= trig_evt;
        end
    end

    always_comb begin
        aux_src = 1'b0;
        case (ctrl_reg[wstu_pkg::CTRL_AUX_SEL_LSB +: 3])
            3'h0, 3'h1, 3'h2, 3'h3: aux_src = trig_sync_reg[ctrl_reg[wstu_pkg::CTRL_AUX_SEL_LSB +: 2]];
            default: aux_src = trig_out_reg[ctrl_reg[wstu_pkg::CTRL_AUX_SEL_LSB +: 2]];
        endcase
    end
    assign aux_rise = aux_src && !aux_prev_reg;

    // Sticky flags: a new event in the clear cycle wins
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            trig_flag_reg <= 1'b0;
            aux_flag_reg <= 1'b0;
            aux_prev_reg <= 1'b0;
        end else begin
            aux_prev_reg <= aux_src;
            if (trig_evt) begin
                trig_flag_reg <= 1'b1;
            end else if (clr_wr) begin
                trig_flag_reg <= 1'b0;
            end
            if (aux_rise) begin
                aux_flag_reg <= 1'b1;
            end else if (clr_wr) begin
                aux_flag_reg <= 1'b0;
            end
        end
    end

    // Trigger outputs: bit 0 mirrors the trigger pulse, bit 1 the waiting state
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            trig_out_reg <= 4'h0;
        end else begin
            trig_out_reg <= {2'b00, state_reg == wstu_pkg::SEQ_WAITING, trig_evt};
        end
    end

    // Register write side
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ctrl_reg <= 11'h000;
            level_reg <= 16'h0000;
            hyst_reg <= 16'h0000;
            fsr_reg <= 16'h0000;
            seq_ctrl_reg <= 6'h00;
        end else if (wr_acc) begin
            case (req.adr[7:0])
                wstu_pkg::REG_CTRL: ctrl_reg <= {req.dat[10:2], req.dat[1], 1'b0};
                wstu_pkg::REG_LEVEL: level_reg <= req.dat[15:0];
                wstu_pkg::REG_HYST: hyst_reg <= req.dat[15:0];
                wstu_pkg::REG_FSR: fsr_reg <= req.dat[15:0];
                wstu_pkg::REG_SEQ_CTRL: seq_ctrl_reg <= req.dat[5:0];
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    // Program download into the cache; writing the length restarts loading
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            prog_len_reg <= 11'h000;
            wr_idx_reg <= 10'h000;
        end else if (wr_acc && req.adr[7:0] == wstu_pkg::REG_PROG_LEN) begin
            prog_len_reg <= (req.dat[10:0] > 11'h400) ? 11'h400 : req.dat[10:0];
            wr_idx_reg <= 10'h000;
        end else if (wr_acc && req.adr[7:0] == wstu_pkg::REG_INSTR) begin
            wr_idx_reg <= wr_idx_reg + 10'h001;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (wr_acc && req.adr[7:0] == wstu_pkg::REG_INSTR) begin
            cache_reg[wr_idx_reg] <= req.dat[15:0];
        end
    end

    assign ready = seq_ctrl_reg[wstu_pkg::SEQ_LOADED_BIT] && !seq_ctrl_reg[wstu_pkg::SEQ_DLPEND_BIT]
                   && prog_len_reg != 11'h000;
    assign instr = cache_reg[pc_reg];

    // One instruction per clock; a wait instruction holds until a trigger
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_reg <= wstu_pkg::SEQ_NOT_READY;
            pc_reg <= 10'h000;
        end else if (!ready) begin
            state_reg <= wstu_pkg::SEQ_NOT_READY;
            pc_reg <= 10'h000;
        end else begin
            case (state_reg)
                wstu_pkg::SEQ_NOT_READY, wstu_pkg::SEQ_IDLE: begin
                    pc_reg <= 10'h000;
                    state_reg <= seq_ctrl_reg[wstu_pkg::SEQ_RUN_BIT] ? wstu_pkg::SEQ_RUNNING
                                                                     : wstu_pkg::SEQ_IDLE;
                end
                wstu_pkg::SEQ_RUNNING: begin
                    if (instr[wstu_pkg::OP_WAIT_BIT] && !trig_evt) begin
                        state_reg <= wstu_pkg::SEQ_WAITING;
                    end else if (instr[wstu_pkg::OP_END_BIT]
                                 || 11'(pc_reg) + 11'h001 >= prog_len_reg) begin
                        pc_reg <= 10'h000;
                        state_reg <= seq_ctrl_reg[wstu_pkg::SEQ_RERUN_BIT]
                                     ? wstu_pkg::SEQ_RUNNING : wstu_pkg::SEQ_IDLE;
                    end else begin
                        pc_reg <= pc_reg + 10'h001;
                    end
                end
                wstu_pkg::SEQ_WAITING: begin
                    if (trig_evt) begin
                        state_reg <= wstu_pkg::SEQ_RUNNING;
                        pc_reg <= pc_reg + 10'h001;
                    end
                end
                default: state_reg <= wstu_pkg::SEQ_NOT_READY;
            endcase
        end
    end

    assign mem_pct = 7'((32'(prog_len_reg) * 32'(wstu_pkg::PCT_FULL))
                        / 32'(wstu_pkg::CACHE_DEPTH));

    always_comb begin
        rd_data = 32'h0000_0000;
        case (req.adr[7:0])
            wstu_pkg::REG_CTRL: rd_data = {21'h00_0000, ctrl_reg};
            wstu_pkg::REG_LEVEL: rd_data = {16'h0000, level_reg};
            wstu_pkg::REG_HYST: rd_data = {16'h0000, hyst_reg};
            wstu_pkg::REG_FSR: rd_data = {16'h0000, fsr_reg};
            wstu_pkg::REG_SEQ_CTRL: rd_data = {26'h000_0000, seq_ctrl_reg};
            wstu_pkg::REG_PROG_LEN: rd_data = {14'h0000, mem_pct, prog_len_reg};
            wstu_pkg::REG_STATUS: rd_data = {26'h000_0000, aux_flag_reg, trig_flag_reg,
                                             state_reg};
            wstu_pkg::REG_PC: rd_data = {22'h00_0000, pc_reg};
            wstu_pkg::REG_CMDTAB: rd_data = {30'h0000_0000,
                                             seq_ctrl_reg[wstu_pkg::SEQ_CT_LSB +: 2]};
            wstu_pkg::REG_ID: rd_data = wstu_pkg::BLOCK_ID;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // Classic Wishbone: ack one cycle after strobe, dropped the next cycle
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req.cyc && req.stb && !ack_reg;
            if (rd_acc) begin
                dat_reg <= rd_data;
            end
        end
    end

    assign wb_ack_out = ack_reg;
    assign wb_dat_out = dat_reg;
    assign trig_out = trig_out_reg;
    assign trig_pulse_out = trig_pulse_reg;
    assign pc_out = pc_reg;
    assign seq_state_out = state_reg;
endmodule // wstu_top
`default_nettype wire

// [design/wstu_pkg.sv]
`default_nettype none
package wstu_pkg;
    // Slope selection codes
    localparam logic [1:0] SLOPE_LEVEL = 2'h0;
    localparam logic [1:0] SLOPE_RISE = 2'h1;
    localparam logic [1:0] SLOPE_FALL = 2'h2;
    localparam logic [1:0] SLOPE_BOTH = 2'h3;

    localparam int SAMPLE_W = 16;
    localparam int PC_W = 10;
    localparam int CACHE_DEPTH = 1024;
    localparam int INSTR_W = 16;
    localparam logic [6:0] PCT_FULL = 7'h64;
    localparam logic [15:0] PCT_SCALE = 16'h0064;

    // Clock timing
    localparam real CLK_PERIOD_NS = 10.0;
    localparam real INSTR_TIME_NS = 4.44;
    localparam int INSTR_CYCLES = 1;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LEVEL = 8'h04;
    localparam logic [7:0] REG_HYST = 8'h08;
    localparam logic [7:0] REG_FSR = 8'h0C;
    localparam logic [7:0] REG_SEQ_CTRL = 8'h10;
    localparam logic [7:0] REG_PROG_LEN = 8'h14;
    localparam logic [7:0] REG_INSTR = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1C;
    localparam logic [7:0] REG_PC = 8'h20;
    localparam logic [7:0] REG_CMDTAB = 8'h24;
    localparam logic [7:0] REG_ID = 8'h28;
    localparam logic [31:0] BLOCK_ID = 32'h5157_0001; // Arbitrary value

    // Control register fields
    localparam int CTRL_FORCE_BIT = 0;
    localparam int CTRL_GATE_EN_BIT = 1;
    localparam int CTRL_GATE_SEL_BIT = 2;
    localparam int CTRL_HYST_REL_BIT = 3;
    localparam int CTRL_SLOPE_LSB = 4;
    localparam int CTRL_AUX_SEL_LSB = 6;
    localparam int CTRL_CLR_BIT = 9;
    localparam int CTRL_SRC_BIT = 10;

    // Sequencer control fields
    localparam int SEQ_RUN_BIT = 0;
    localparam int SEQ_RERUN_BIT = 1;
    localparam int SEQ_LOADED_BIT = 2;
    localparam int SEQ_DLPEND_BIT = 3;
    localparam int SEQ_CT_LSB = 4;

    // Instruction opcodes: top bit waits for trigger, bit 14 ends the program, rest is payload
    localparam int OP_WAIT_BIT = 15;
    localparam int OP_END_BIT = 14;

    typedef enum logic [3:0] {
        SEQ_NOT_READY = 4'b0001,
        SEQ_IDLE = 4'b0010,
        SEQ_RUNNING = 4'b0100,
        SEQ_WAITING = 4'b1000
    } wstu_seq_e;

    typedef enum logic [1:0] {
        CT_NONE = 2'h0,
        CT_OK = 2'h1,
        CT_ERROR = 2'h2
    } wstu_ct_e;

    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic cyc;
        logic stb;
    } wstu_wb_req_s;

    typedef struct packed {
        logic [31:0] dat;
        logic ack;
    } wstu_wb_rsp_s;

    typedef struct packed {
        logic [1:0] slope;
        logic hyst_rel;
        logic signed [SAMPLE_W-1:0] level;
        logic [15:0] hyst;
        logic [15:0] fsr;
    } wstu_trig_cfg_s;
endpackage
`default_nettype wire

// [design/wstu_analog_trig.sv]
`default_nettype none
module wstu_analog_trig (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic signed [wstu_pkg::SAMPLE_W-1:0] sample_in,
    input wire wstu_pkg::wstu_trig_cfg_s cfg_in,
    output logic hit_out
);
    logic armed_reg;
    logic above_reg;
    logic [31:0] rel_prod;
    logic [17:0] hyst_amt;
    logic signed [17:0] s_ext;
    logic signed [17:0] lvl_ext;
    logic above;
    logic rise;
    logic fall;
    logic edge_hit;
    logic rearm;

    // Relative mode: percent of full scale, not clamped at 100
    assign rel_prod = cfg_in.hyst * cfg_in.fsr;
    assign hyst_amt = cfg_in.hyst_rel ? 18'(rel_prod / 32'(wstu_pkg::PCT_SCALE))
                                      : {2'b00, cfg_in.hyst};
    assign s_ext = 18'(sample_in);
    assign lvl_ext = 18'(cfg_in.level);
    assign above = s_ext >= lvl_ext;
    assign rise = above && !above_reg;
    assign fall = !above && above_reg;

    always_comb begin
        edge_hit = 1'b0;
        case (cfg_in.slope)
            wstu_pkg::SLOPE_LEVEL: edge_hit = above;
            wstu_pkg::SLOPE_RISE: edge_hit = rise;
            wstu_pkg::SLOPE_FALL: edge_hit = fall;
            default: edge_hit = rise || fall;
        endcase
    end

    // Hysteresis side follows the edge: below level for rise, above for fall
    always_comb begin
        rearm = 1'b1;
        if (hyst_amt != 18'h0_0000) begin
            case (cfg_in.slope)
                wstu_pkg::SLOPE_FALL: rearm = s_ext >= lvl_ext + $signed(hyst_amt);
                wstu_pkg::SLOPE_BOTH: rearm = (s_ext >= lvl_ext + $signed(hyst_amt))
                                           || (s_ext <= lvl_ext - $signed(hyst_amt));
                default: rearm = s_ext <= lvl_ext - $signed(hyst_amt);
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            above_reg <= 1'b0;
        end else begin
            above_reg <= above;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            armed_reg <= 1'b1;
        end else if (armed_reg && edge_hit) begin
            armed_reg <= 1'b0;
        end else if (!armed_reg && rearm) begin
            armed_reg <= 1'b1;
        end
    end

    assign hit_out = armed_reg && edge_hit;
endmodule // wstu_analog_trig
`default_nettype wire

// [verification/wstu_props.sv]
`default_nettype none
module wstu_props (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [31:0] wb_adr_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic wb_we_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic signed [wstu_pkg::SAMPLE_W-1:0] sample_a_in,
    input wire logic signed [wstu_pkg::SAMPLE_W-1:0] sample_b_in,
    input wire logic [3:0] trig_in,
    input wire logic [3:0] trig_out,
    input wire logic trig_pulse_out,
    input wire logic [wstu_pkg::PC_W-1:0] pc_out,
    input wire logic [3:0] seq_state_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    logic taken;
    logic rd_taken;
    assign taken = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign rd_taken = taken && !wb_we_in;

    AST_ACK_LAT: assert property (taken |=> wb_ack_out)
        else $error("ack missing one cycle after request");
    AST_ACK_DROP: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    AST_FORCE: assert property (taken && wb_we_in && wb_adr_in[7:0] == wstu_pkg::REG_CTRL
        && wb_dat_in[wstu_pkg::CTRL_FORCE_BIT] |=> trig_pulse_out)
        else $error("force write gave no trigger pulse");
    AST_UNMAPPED: assert property (rd_taken && wb_adr_in[7:0] == 8'h80
        |=> wb_dat_out == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_ID: assert property (rd_taken && wb_adr_in[7:0] == wstu_pkg::REG_ID
        |=> wb_dat_out == wstu_pkg::BLOCK_ID)
        else $error("identity read wrong");
    AST_PC_READ: assert property (rd_taken && wb_adr_in[7:0] == wstu_pkg::REG_PC
        |=> wb_dat_out[wstu_pkg::PC_W-1:0] == $past(pc_out))
        else $error("counter read differs from counter output");
    AST_ONEHOT: assert property ($onehot(seq_state_out))
        else $error("sequencer state not one-hot");
    AST_PC_STEP: assert property (seq_state_out == wstu_pkg::SEQ_RUNNING
        && $past(seq_state_out) == wstu_pkg::SEQ_RUNNING
        |-> pc_out == $past(pc_out) + 10'h001 || pc_out == 10'h000)
        else $error("counter did not advance one step per cycle");
    AST_TRIG_HI: assert property (trig_out[3:2] == 2'b00)
        else $error("unused trigger outputs active");
    AST_RST_STATE: assert property ($fell(sys_rst_in)
        |-> seq_state_out == wstu_pkg::SEQ_NOT_READY && pc_out == 10'h000)
        else $error("state after reset not not-ready");
endmodule // wstu_props
`default_nettype wire

// [verification/wstu_far_end.sv]
`default_nettype none
module wstu_far_end (
    input wire logic ref_clk_in,
    input wire logic signed [15:0] level_in,
    input wire logic [3:0] trig_req_in,
    output logic signed [wstu_pkg::SAMPLE_W-1:0] sample_a_out,
    output logic signed [wstu_pkg::SAMPLE_W-1:0] sample_b_out,
    output logic [3:0] trig_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sample_a_out = 16'h8000;
        sample_b_out = 16'h0000;
        trig_out = 4'h0;
    end
    // Unused source wanders every cycle so a wrong source mux shows up
    always @(posedge ref_clk_in) begin
        sample_a_out <= level_in;
        sample_b_out <= sample_b_out + 16'h1357;
        trig_out <= trig_req_in;
    end
endmodule // wstu_far_end
`default_nettype wire

// [verification/test_waveform_sequencer_trigger_unit.sv]
`default_nettype none
module test_waveform_sequencer_trigger_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] adr = 32'h0000_0000;
    logic [31:0] dat = 32'h0000_0000;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic [31:0] dat_o;
    logic ack;
    logic signed [15:0] lvl = 16'h8000;
    logic [3:0] treq = 4'h0;
    logic signed [15:0] sa;
    logic signed [15:0] sb;
    logic [3:0] tin;
    logic [3:0] tout;
    logic pulse;
    logic [9:0] pc;
    logic [3:0] state;
    logic [15:0] prog [4] = '{16'h0000, 16'h8000, 16'h0000, 16'h4000};
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] exp_q [$];

    wstu_top i_dut (.ref_clk_in(ref_clk), .sys_rst_in(rst), .wb_adr_in(adr), .wb_dat_in(dat),
        .wb_sel_in(4'hF), .wb_we_in(we), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_dat_out(dat_o),
        .wb_ack_out(ack), .sample_a_in(sa), .sample_b_in(sb), .trig_in(tin), .trig_out(tout),
        .trig_pulse_out(pulse), .pc_out(pc), .seq_state_out(state));
    wstu_far_end i_far (.ref_clk_in(ref_clk), .level_in(lvl), .trig_req_in(treq),
        .sample_a_out(sa), .sample_b_out(sb), .trig_out(tin));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            errors++;
            $display("[FAIL] %0t read %h expected %h", $time, seen, want);
        end
    endtask

    task automatic results;
        if (errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
        @(posedge ref_clk);
        adr <= {24'h00_0000, a};
        dat <= d;
        we <= w;
        cyc <= 1'b1;
        stb <= 1'b1;
        do @(posedge ref_clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, d, 1'b1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 32'h0000_0000, 1'b0);
    endtask

    // Flags are cleared by a pulse on the clear bit, then the bit is dropped again
    task automatic clr(input logic [31:0] c);
        wr(wstu_pkg::REG_CTRL, c | 32'h0000_0200);
        wr(wstu_pkg::REG_CTRL, c);
    endtask

    task automatic ana(input logic [15:0] v);
        @(posedge ref_clk);
        lvl <= v;
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic pins(input logic [3:0] v);
        @(posedge ref_clk);
        treq <= v;
        repeat (6) @(posedge ref_clk);
    endtask

    function automatic logic [31:0] st(input logic f, input logic x, input logic [3:0] s);
        return {26'h000_0000, x, f, s};
    endfunction

    always @(posedge ref_clk) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) chk(dat_o, exp_q.pop_front());
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 5000) begin
            errors++;
            results();
        end
    end

    initial begin
        void'($urandom(50));
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(wstu_pkg::REG_STATUS, st(0, 0, 4'h1));
        rd(wstu_pkg::REG_PC, 32'h0000_0000);
        rd(wstu_pkg::REG_CMDTAB, 32'h0000_0000);
        rd(8'h80, 32'h0000_0000);
        rd(wstu_pkg::REG_ID, wstu_pkg::BLOCK_ID);
        wr(wstu_pkg::REG_CTRL, 32'h0000_0001);
        rd(wstu_pkg::REG_STATUS, st(1, 0, 4'h1));
        wr(wstu_pkg::REG_LEVEL, 32'h0000_0100);
        for (int s = 0; s < 4; s++) begin
            ana(16'h0000);
            clr(32'(s) << 4);
            ana(16'h0200);
            rd(wstu_pkg::REG_STATUS, st(s != 2, 0, 4'h1));
            // Level mode keeps firing while the sample stays above, so its flag comes back
            clr(32'(s) << 4);
            ana(16'h0000);
            rd(wstu_pkg::REG_STATUS, st(s != 1, 0, 4'h1));
        end
        wr(wstu_pkg::REG_HYST, 32'h0000_0080);
        ana(16'h0000);
        clr(32'h0000_0010);
        ana(16'h0200);
        rd(wstu_pkg::REG_STATUS, st(1, 0, 4'h1));
        ana(16'(16'h0081 + $urandom % 127));
        clr(32'h0000_0010);
        ana(16'h0200);
        rd(wstu_pkg::REG_STATUS, st(0, 0, 4'h1));
        ana(16'h0040);
        ana(16'h0200);
        rd(wstu_pkg::REG_STATUS, st(1, 0, 4'h1));
        // Relative 200 percent of 0x100 is 0x200; a clamp at 100 percent would rearm at 0
        wr(wstu_pkg::REG_FSR, 32'h0000_0100);
        wr(wstu_pkg::REG_HYST, 32'h0000_00C8);
        ana(16'hFE00);
        clr(32'h0000_0018);
        ana(16'h0200);
        rd(wstu_pkg::REG_STATUS, st(1, 0, 4'h1));
        ana(16'hFF80);
        clr(32'h0000_0018);
        ana(16'h0200);
        rd(wstu_pkg::REG_STATUS, st(0, 0, 4'h1));
        ana(16'hFE80);
        ana(16'h0200);
        rd(wstu_pkg::REG_STATUS, st(1, 0, 4'h1));
        wr(wstu_pkg::REG_HYST, 32'h0000_0000);
        for (int g = 0; g < 2; g++) begin
            pins(4'h0);
            ana(16'h0000);
            clr(32'h0000_0012 | (32'(g) << 2));
            ana(16'h0200);
            rd(wstu_pkg::REG_STATUS, st(0, 0, 4'h1));
            pins(4'(4 << g));
            ana(16'h0000);
            ana(16'h0200);
            rd(wstu_pkg::REG_STATUS, st(1, 0, 4'h1));
        end
        ana(16'h0000);
        for (int a = 0; a < 8; a++) begin
            pins(4'h0);
            clr(32'(a) << 6);
            if (a < 4) pins(4'(1 << a));
            else begin
                wr(wstu_pkg::REG_CTRL, (32'(a) << 6) | 32'h0000_0001);
                pins(4'h0);
            end
            rd(wstu_pkg::REG_STATUS, st(a > 3, a < 5, 4'h1));
        end
        // Source B steps through the whole range, so the level is crossed within eight samples
        clr(32'h0000_0400);
        ana(16'h0000);
        rd(wstu_pkg::REG_STATUS, st(1, 0, 4'h1));
        wr(wstu_pkg::REG_CTRL, 32'h0000_0000);
        pins(4'h0);
        clr(32'h0000_0000);
        wr(wstu_pkg::REG_SEQ_CTRL, 32'h0000_000C);
        rd(wstu_pkg::REG_STATUS, st(0, 0, 4'h1));
        for (int c = 0; c < 3; c++) begin
            wr(wstu_pkg::REG_SEQ_CTRL, (32'(c) << 4) | 32'h0000_0004);
            rd(wstu_pkg::REG_CMDTAB, 32'(c));
        end
        wr(wstu_pkg::REG_PROG_LEN, 32'h0000_07D0);
        rd(wstu_pkg::REG_PROG_LEN, 32'h0003_2400);
        wr(wstu_pkg::REG_PROG_LEN, 32'h0000_0004);
        for (int i = 0; i < 4; i++) wr(wstu_pkg::REG_INSTR, {16'h0000, prog[i]});
        rd(wstu_pkg::REG_PROG_LEN, 32'h0000_0004);
        wr(wstu_pkg::REG_SEQ_CTRL, 32'h0000_0004);
        rd(wstu_pkg::REG_STATUS, st(0, 0, 4'h2));
        wr(wstu_pkg::REG_SEQ_CTRL, 32'h0000_0007);
        repeat (4) @(posedge ref_clk);
        rd(wstu_pkg::REG_STATUS, st(0, 0, 4'h8));
        rd(wstu_pkg::REG_PC, 32'h0000_0001);
        wr(wstu_pkg::REG_CTRL, 32'h0000_0001);
        repeat (10) @(posedge ref_clk);
        rd(wstu_pkg::REG_STATUS, st(1, 0, 4'h8));
        rd(wstu_pkg::REG_PC, 32'h0000_0001);
        results();
    end
endmodule // test_waveform_sequencer_trigger_unit

bind wstu_top wstu_props i_props (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in), .wb_sel_in(wb_sel_in), .wb_we_in(wb_we_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .sample_a_in(sample_a_in), .sample_b_in(sample_b_in),
    .trig_in(trig_in), .trig_out(trig_out), .trig_pulse_out(trig_pulse_out),
    .pc_out(pc_out), .seq_state_out(seq_state_out));
`default_nettype wire
